// File: core/dma_burst_pkg.sv
// constants and carrier types for the pci burst and threshold control
// assumes a 12-bit offset inside the 4k window of base address register 0
package dma_burst_pkg;

    // ********************************
    // register map
    // ********************************
    localparam logic [11:0] ISO_CTRL_OFFSET = 12'h0800;
    localparam logic [11:0] ASYNC_CTRL_OFFSET = 12'h0808;
    localparam logic [11:0] LINK_OPT_OFFSET = 12'h0840;
    localparam int VENDOR_HALF_BIT = 11;

    localparam logic [31:0] ISO_CTRL_RESET = 32'h0000_7373;
    localparam logic [31:0] ASYNC_CTRL_RESET = 32'h0010_7373;
    localparam logic [31:0] LINK_OPT_RESET = 32'h0000_0020;

    localparam logic [31:0] ISO_CTRL_MASK = 32'h0000_ffff;
    localparam logic [31:0] ASYNC_CTRL_MASK = 32'h01ff_ffff;
    localparam logic [31:0] LINK_OPT_MASK = 32'hbf00_003f;

    // ********************************
    // field positions
    // ********************************
    localparam int SEND_BURST_LSB = 12;
    localparam int SEND_THR_LSB = 8;
    localparam int RECV_BURST_LSB = 4;
    localparam int RECV_THR_LSB = 0;
    localparam int READY_LEVEL_LSB = 16;
    localparam int RETRY_MAX_BIT = 24;

    localparam logic [7:0] READY_LEVEL_MAX = 8'h20;
    localparam int QUADS_PER_STEP_LOG2 = 4;

    // channel order: iso send, iso receive, async transmit, async receive
    localparam int CHAN_ISO_SEND = 0;
    localparam int CHAN_ISO_RECEIVE = 1;
    localparam int CHAN_ASYNC_TRANSMIT = 2;
    localparam int CHAN_ASYNC_RECEIVE = 3;
    localparam int NUM_CHAN = 4;

    localparam int FIFO_WIDTH = 32;
    localparam int FIFO_DEPTH = 8;

    typedef struct packed {
        logic [11:0] level;
        logic [11:0] room;
        logic [11:0] pkt_left;
        logic whole;
        logic busy;
    } chan_in_t;

    typedef struct packed {
        logic req;
        logic [11:0] burst;
    } chan_out_t;

endpackage

// File: core/dma_burst_ctrl.sv
// pci request and burst sizing for the four dma engines, link packet-ready
// assumes every input comes from logic on I_CLK, the pci clock
`timescale 1ns/1ps
`default_nettype none

// ********************************
// staging fifo
// ********************************
module stage_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic [WIDTH-1:0] i_data,
    input wire logic i_valid,
    output logic o_ready,
    output logic [WIDTH-1:0] o_data,
    output logic o_valid,
    input wire logic i_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic [AW-1:0] next_wptr;
    logic [AW-1:0] next_rptr;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign o_ready = (count != (AW+1)'(DEPTH));
    assign o_valid = (count != '0);
    assign o_data = mem[rptr];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    always_comb
    begin
        next_wptr = push ? AW'(wptr + 1'b1) : wptr;
        next_rptr = pop ? AW'(rptr + 1'b1) : rptr;
        next_count = count;
        if (push && !pop)
        begin
            next_count = (AW+1)'(count + 1'b1);
        end
        else if (pop && !push)
        begin
            next_count = (AW+1)'(count - 1'b1);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end
        else if (i_ce)
        begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            count <= next_count;
            if (push)
            begin
                mem[wptr] <= i_data;
            end
        end
    end
endmodule

// Notes on behaviour
// - vendor registers answer only in the upper 2k of the 4k window.
// - an eeprom load pulse sets the starting contents of all three registers.
// - iso send fetches at most 16*(n+1) quadlets, n in bits 15:12, reset 7.
// - iso send asks at 16*(n+1) free quadlets, or sooner if less remains.
// - iso receive writes at most 16*(n+1) quadlets, n in bits 7:4, reset 7.
// - iso receive asks at 16*(n+1) held quadlets, or on overflow or packet.
// - with bit 24 set a retried packet uses the largest ready level 0x20.
// - the link is told a packet is ready once 16*n quadlets of it are held.
// - a packet wholly in the transmit fifo is ready whatever its length.
// - async transmit and read response fetch at most 16*(n+1) quadlets.
// - async transmit asks at 16*(n+1) free, or sooner if less remains.
// - async receive and physical write move at most 16*(n+1) quadlets.
// - async receive asks at 16*(n+1) held, or sooner on overflow or packet.
// - a burst never exceeds packet size, host buffer, fifo or cache line.
// - the iso control register resets to 0000 7373h.
module dma_burst_ctrl (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_CE,
    input wire logic [11:0] I_REG_ADDR,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [31:0] I_REG_WDATA,
    output logic [31:0] O_REG_RDATA,
    output logic O_REG_ACK,
    input wire logic I_EE_LOAD,
    input wire logic [31:0] I_EE_ISO,
    input wire logic [31:0] I_EE_ASYNC,
    input wire logic [31:0] I_EE_LINK,
    input wire logic [7:0] I_CACHE_LINE,
    input wire dma_burst_pkg::chan_in_t [3:0] I_CHAN,
    output dma_burst_pkg::chan_out_t [3:0] O_CHAN,
    input wire logic [11:0] I_TX_FILL,
    input wire logic I_TX_WHOLE,
    input wire logic I_TX_RETRY,
    output logic O_PKT_READY,
    output logic [31:0] O_LINK_OPTIONS,
    input wire logic [31:0] I_TX_DATA,
    input wire logic I_TX_VALID,
    output logic O_TX_READY,
    output logic [31:0] O_LINK_DATA,
    output logic O_LINK_VALID,
    input wire logic I_LINK_READY
);
    logic [31:0] iso_dma_pci_control;
    logic [31:0] async_dma_pci_control;
    logic [31:0] link_core_options;
    logic [31:0] next_iso;
    logic [31:0] next_async;
    logic [31:0] next_link;
    logic [31:0] next_rdata;
    logic next_ack;
    logic in_vendor_half;
    logic [11:0] cache_quads;
    dma_burst_pkg::chan_out_t [3:0] next_chan;
    logic next_pkt_ready;
    logic [7:0] ready_n;
    logic [11:0] ready_quads;

    function automatic logic [11:0] step_quads(input logic [3:0] n);
        step_quads = 12'(({8'h00, n} + 12'h001)
            << dma_burst_pkg::QUADS_PER_STEP_LOG2);
    endfunction

    function automatic logic [11:0] min12(input logic [11:0] a,
        input logic [11:0] b);
        min12 = (a < b) ? a : b;
    endfunction

    // ********************************
    // register port
    // ********************************
    assign in_vendor_half = I_REG_ADDR[dma_burst_pkg::VENDOR_HALF_BIT];

    // eeprom load takes priority over a host write in the same cycle
    always_comb
    begin
        next_iso = iso_dma_pci_control;
        next_async = async_dma_pci_control;
        next_link = link_core_options;
        next_rdata = O_REG_RDATA;
        next_ack = 1'b0;
        if (I_EE_LOAD)
        begin
            next_iso = I_EE_ISO & dma_burst_pkg::ISO_CTRL_MASK;
            next_async = I_EE_ASYNC & dma_burst_pkg::ASYNC_CTRL_MASK;
            next_link = I_EE_LINK & dma_burst_pkg::LINK_OPT_MASK;
        end
        else if (I_REG_WR && in_vendor_half)
        begin
            next_ack = 1'b1;
            unique case (I_REG_ADDR)
                dma_burst_pkg::ISO_CTRL_OFFSET:
                    next_iso = I_REG_WDATA & dma_burst_pkg::ISO_CTRL_MASK;
                dma_burst_pkg::ASYNC_CTRL_OFFSET:
                    next_async = I_REG_WDATA & dma_burst_pkg::ASYNC_CTRL_MASK;
                dma_burst_pkg::LINK_OPT_OFFSET:
                    next_link = I_REG_WDATA & dma_burst_pkg::LINK_OPT_MASK;
                default:
                    next_ack = 1'b1;
            endcase
        end
        if (I_REG_RD && in_vendor_half)
        begin
            next_ack = 1'b1;
            unique case (I_REG_ADDR)
                dma_burst_pkg::ISO_CTRL_OFFSET:
                    next_rdata = iso_dma_pci_control;
                dma_burst_pkg::ASYNC_CTRL_OFFSET:
                    next_rdata = async_dma_pci_control;
                dma_burst_pkg::LINK_OPT_OFFSET:
                    next_rdata = link_core_options;
                default:
                    next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // ********************************
    // per-engine request and burst size
    // ********************************
    // a zero cache line size means no cache-line cap
    assign cache_quads = (I_CACHE_LINE == 8'h00) ? 12'hfff
        : {4'h0, I_CACHE_LINE};

    genvar gi;
    generate
        for (gi = 0; gi < dma_burst_pkg::NUM_CHAN; gi++)
        begin : g_chan
            localparam bit IS_SEND = (gi == dma_burst_pkg::CHAN_ISO_SEND)
                || (gi == dma_burst_pkg::CHAN_ASYNC_TRANSMIT);
            localparam bit IS_ISO = (gi == dma_burst_pkg::CHAN_ISO_SEND)
                || (gi == dma_burst_pkg::CHAN_ISO_RECEIVE);
            localparam int BURST_LSB = IS_SEND
                ? dma_burst_pkg::SEND_BURST_LSB
                : dma_burst_pkg::RECV_BURST_LSB;
            localparam int THR_LSB = IS_SEND ? dma_burst_pkg::SEND_THR_LSB
                : dma_burst_pkg::RECV_THR_LSB;
            logic [31:0] ctl;
            logic [11:0] max_burst;
            logic [11:0] thr;
            logic [11:0] lvl;
            logic [11:0] room;
            logic [11:0] burst;
            logic cond;

            assign ctl = IS_ISO ? iso_dma_pci_control : async_dma_pci_control;
            assign max_burst = step_quads(ctl[BURST_LSB+:4]);
            assign thr = step_quads(ctl[THR_LSB+:4]);
            assign lvl = I_CHAN[gi].level;
            assign room = I_CHAN[gi].room;
            // send: level is free space, room is data left to fetch
            // receive: level is data held, room is host buffer space left
            if (IS_SEND)
            begin : g_send
                assign cond = (lvl >= thr)
                    || (room != 12'h000 && room < lvl);
            end
            else
            begin : g_recv
                assign cond = (lvl >= thr)
                    || (lvl > room)
                    || (I_CHAN[gi].whole && lvl != 12'h000);
            end
            assign burst = min12(min12(max_burst, min12(lvl, room)),
                min12(I_CHAN[gi].pkt_left, cache_quads));
            assign next_chan[gi].burst = burst;
            assign next_chan[gi].req = cond && !I_CHAN[gi].busy
                && (burst != 12'h000);
        end
    endgenerate

    // ********************************
    // link packet-ready
    // ********************************
    // codes above the largest level are treated as the largest
    assign ready_n = (I_TX_RETRY
        && async_dma_pci_control[dma_burst_pkg::RETRY_MAX_BIT])
        ? dma_burst_pkg::READY_LEVEL_MAX
        : ((async_dma_pci_control[dma_burst_pkg::READY_LEVEL_LSB+:8]
            > dma_burst_pkg::READY_LEVEL_MAX)
            ? dma_burst_pkg::READY_LEVEL_MAX
            : async_dma_pci_control[dma_burst_pkg::READY_LEVEL_LSB+:8]);
    assign ready_quads = 12'({4'h0, ready_n}
        << dma_burst_pkg::QUADS_PER_STEP_LOG2);
    assign next_pkt_ready = I_TX_WHOLE
        || (I_TX_FILL >= ready_quads && I_TX_FILL != 12'h000);

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            iso_dma_pci_control <= dma_burst_pkg::ISO_CTRL_RESET;
            async_dma_pci_control <= dma_burst_pkg::ASYNC_CTRL_RESET;
            link_core_options <= dma_burst_pkg::LINK_OPT_RESET;
            O_REG_RDATA <= 32'h0000_0000;
            O_REG_ACK <= 1'b0;
            O_CHAN <= '0;
            O_PKT_READY <= 1'b0;
        end
        else if (I_CE)
        begin
            iso_dma_pci_control <= next_iso;
            async_dma_pci_control <= next_async;
            link_core_options <= next_link;
            O_REG_RDATA <= next_rdata;
            O_REG_ACK <= next_ack;
            O_CHAN <= next_chan;
            O_PKT_READY <= next_pkt_ready;
        end
    end

    assign O_LINK_OPTIONS = link_core_options;

    // ********************************
    // transmit data staging
    // ********************************
    // absorbs short link stalls so a pci burst need not stop mid-transfer
    stage_fifo #(
        .WIDTH(dma_burst_pkg::FIFO_WIDTH),
        .DEPTH(dma_burst_pkg::FIFO_DEPTH)
    ) u_stage (
        .i_clk(I_CLK),
        .i_sys_rst(I_SYS_RST),
        .i_ce(I_CE),
        .i_data(I_TX_DATA),
        .i_valid(I_TX_VALID),
        .o_ready(O_TX_READY),
        .o_data(O_LINK_DATA),
        .o_valid(O_LINK_VALID),
        .i_ready(I_LINK_READY)
    );
endmodule

`default_nettype wire

// File: dv/dma_burst_props.sv
// port checker for dma_burst_ctrl
// assumes the single pci clock domain; bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module dma_burst_props (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_CE,
    input wire logic [11:0] I_REG_ADDR,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic O_REG_ACK,
    input wire logic [7:0] I_CACHE_LINE,
    input wire dma_burst_pkg::chan_in_t [3:0] I_CHAN,
    input wire dma_burst_pkg::chan_out_t [3:0] O_CHAN,
    input wire logic I_TX_WHOLE,
    input wire logic O_PKT_READY,
    input wire logic [31:0] O_LINK_DATA,
    input wire logic O_LINK_VALID,
    input wire logic I_LINK_READY
);
    // ********
    // properties
    // ********
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_SYS_RST);
    wire hit = I_CE && (I_REG_WR || I_REG_RD);
    property p_ack_up;
        hit && I_REG_ADDR[11] |=> O_REG_ACK;
    endproperty
    a_ack_up: assert property (p_ack_up)
        else $error("no ack");
    property p_ack_low;
        hit && !I_REG_ADDR[11] |=> !O_REG_ACK;
    endproperty
    a_ack_low: assert property (p_ack_low)
        else $error("stray ack");
    property p_whole;
        I_CE && I_TX_WHOLE |=> O_PKT_READY;
    endproperty
    a_whole: assert property (p_whole)
        else $error("whole packet not ready");
    property p_busy;
        I_CE && I_CHAN[0].busy |=> !O_CHAN[0].req;
    endproperty
    a_busy: assert property (p_busy)
        else $error("request while busy");
    property p_pkt;
        I_CE |=> O_CHAN[0].burst <= $past(I_CHAN[0].pkt_left);
    endproperty
    a_pkt: assert property (p_pkt)
        else $error("burst above packet");
    property p_cache;
        I_CE && I_CACHE_LINE != 8'h00
            |=> O_CHAN[2].burst <= {4'h0, $past(I_CACHE_LINE)};
    endproperty
    a_cache: assert property (p_cache)
        else $error("burst above cache line");
    property p_send;
        I_CE && !I_CHAN[0].busy && I_CHAN[0].level >= 12'h100
            && I_CHAN[0].room != 12'h000 && I_CHAN[0].pkt_left != 12'h000
            |=> O_CHAN[0].req;
    endproperty
    a_send: assert property (p_send)
        else $error("send request missing");
    property p_hold;
        I_CE && O_LINK_VALID && !I_LINK_READY
            |=> O_LINK_VALID && $stable(O_LINK_DATA);
    endproperty
    a_hold: assert property (p_hold)
        else $error("link word dropped");
endmodule
bind dma_burst_ctrl dma_burst_props u_props (.I_CLK, .I_SYS_RST, .I_CE,
    .I_REG_ADDR, .I_REG_WR, .I_REG_RD, .O_REG_ACK, .I_CACHE_LINE, .I_CHAN,
    .O_CHAN, .I_TX_WHOLE, .O_PKT_READY, .O_LINK_DATA, .O_LINK_VALID,
    .I_LINK_READY);
`default_nettype wire

// File: dv/link_sink_model.sv
// link core stand-in taking words off the staging fifo
// assumes valid and data change only on the pci clock
`timescale 1ns/1ps
`default_nettype none
module link_sink_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_hold,
    input wire logic i_valid,
    input wire logic [31:0] i_data,
    output logic o_ready,
    output logic o_got,
    output logic [31:0] o_word
);
    integer seed = 32'h3cd6_33ab;
    initial o_ready = 1'b0;
    initial o_got = 1'b0;
    always @(posedge i_clk)
    begin
        o_got <= !i_rst && i_valid && o_ready;
        o_word <= i_data;
        // random stalls; ready moves only after the edge
        #1 o_ready = !i_hold && ($random(seed) % 3 != 0);
    end
endmodule
`default_nettype wire

// File: dv/tb_dma_pci_burst_threshold_ctrl.sv
// self-checking bench for dma_burst_ctrl
// assumes the link sink model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_dma_pci_burst_threshold_ctrl;
    logic I_CLK = 1'b0, I_SYS_RST = 1'b1, I_CE = 1'b1;
    logic [11:0] I_REG_ADDR = 12'h000, I_TX_FILL = 12'h000;
    logic I_REG_WR = 1'b0, I_REG_RD = 1'b0, I_EE_LOAD = 1'b0, O_REG_ACK;
    logic [31:0] I_REG_WDATA = 32'h0000_0000, O_REG_RDATA, O_LINK_OPTIONS;
    logic [31:0] I_EE_ISO, I_EE_ASYNC, I_EE_LINK, O_LINK_DATA, got_word;
    logic [31:0] I_TX_DATA = 32'h0000_0000;
    logic [7:0] I_CACHE_LINE = 8'h00;
    dma_burst_pkg::chan_in_t [3:0] I_CHAN = '0;
    dma_burst_pkg::chan_out_t [3:0] O_CHAN;
    logic I_TX_WHOLE = 1'b0, I_TX_RETRY = 1'b0, I_TX_VALID = 1'b0;
    logic O_PKT_READY, O_TX_READY, O_LINK_VALID, I_LINK_READY, got;
    logic hold = 1'b1;
    logic [32:0] rec;
    logic [32:0] q_reg[$];
    logic [31:0] q_link[$];
    integer seed = 32'h3cd6_33ab;
    int err_count = 0, n_checks = 0, n_acc = 0;
    initial {I_EE_ISO, I_EE_ASYNC, I_EE_LINK} = '0;
    always #5 I_CLK = ~I_CLK;
    dma_burst_ctrl u_dut (.I_CLK, .I_SYS_RST, .I_CE, .I_REG_ADDR, .I_REG_WR,
        .I_REG_RD, .I_REG_WDATA, .O_REG_RDATA, .O_REG_ACK, .I_EE_LOAD,
        .I_EE_ISO, .I_EE_ASYNC, .I_EE_LINK, .I_CACHE_LINE, .I_CHAN, .O_CHAN,
        .I_TX_FILL, .I_TX_WHOLE, .I_TX_RETRY, .O_PKT_READY, .O_LINK_OPTIONS,
        .I_TX_DATA, .I_TX_VALID, .O_TX_READY, .O_LINK_DATA, .O_LINK_VALID,
        .I_LINK_READY);
    link_sink_model u_sink (.i_clk(I_CLK), .i_rst(I_SYS_RST), .i_hold(hold),
        .i_valid(O_LINK_VALID), .i_data(O_LINK_DATA), .o_ready(I_LINK_READY),
        .o_got(got), .o_word(got_word));
    // ********
    // tasks
    // ********
    task chk(input string what, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e)
        begin
            err_count++;
            $display("wrong value %s exp %h seen %h", what, e, s);
        end
    endtask
    task chk1(input string what, input logic e, input logic s);
        chk(what, {31'h0000_0000, e}, {31'h0000_0000, s});
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task tick;
        @(posedge I_CLK);
        #1;
    endtask
    // read: d is the expected word; write: d is written
    task acc(input logic rd, input logic [11:0] a, input logic [31:0] d);
        if (a[11])
            q_reg.push_back({rd, d});
        {I_REG_RD, I_REG_WR, I_REG_ADDR, I_REG_WDATA} = {rd, !rd, a, d};
        tick;
        {I_REG_RD, I_REG_WR} = 2'b00;
        tick;
    endtask
    task eng(input int ch, lv, rm, pk, input logic wh, by, rq, input int bu);
        I_CHAN[ch] = {lv[11:0], rm[11:0], pk[11:0], wh, by};
        tick;
        chk1("request", rq, O_CHAN[ch].req);
        chk("burst", bu, {20'h0_0000, O_CHAN[ch].burst});
    endtask
    task pr(input int fill, input logic wh, rt, e);
        {I_TX_FILL, I_TX_WHOLE, I_TX_RETRY} = {fill[11:0], wh, rt};
        tick;
        chk1("packet ready", e, O_PKT_READY);
    endtask
    always @(negedge I_CLK)
    begin
        if (O_REG_ACK === 1'b1)
        begin
            rec = q_reg.size() ? q_reg.pop_front() : 33'h1_dead_beef;
            if (rec[32])
                chk("read data", rec[31:0], O_REG_RDATA);
        end
        if (got === 1'b1)
            chk("link word", q_link.size() ? q_link.pop_front()
                : 32'hdead_beef, got_word);
    end
    initial
    begin
        repeat (20000) @(posedge I_CLK);
        err_count++;
        tally_and_finish;
    end
    // ********
    // sequence
    // ********
    initial
    begin
        repeat (10) @(posedge I_CLK);
        #1 I_SYS_RST = 1'b0;
        acc(1, 12'h800, 32'h0000_7373);
        acc(1, 12'h808, 32'h0010_7373);
        acc(1, 12'h000, 32'h0000_0000);
        acc(1, 12'h804, 32'h0000_0000);
        for (int i = 0; i < 4; i++)
        begin
            I_EE_ASYNC = $random(seed);
            acc(0, 12'h808, I_EE_ASYNC);
            acc(1, 12'h808, I_EE_ASYNC & 32'h01ff_ffff);
        end
        {I_EE_ISO, I_EE_LINK} = {$random(seed), $random(seed)};
        I_EE_LOAD = 1'b1;
        tick;
        I_EE_LOAD = 1'b0;
        acc(1, 12'h800, I_EE_ISO & 32'h0000_ffff);
        acc(1, 12'h808, I_EE_ASYNC & 32'h01ff_ffff);
        acc(1, 12'h840, I_EE_LINK & 32'hbf00_003f);
        chk("link options", I_EE_LINK & 32'hbf00_003f, O_LINK_OPTIONS);
        $display("test registers done");
        // receive thresholds 16, iso send 64, async transmit 16
        // written only while no packet is queued for the link
        acc(0, 12'h800, 32'h0000_7370);
        acc(0, 12'h808, 32'h0010_7070);
        eng(1, 16, 100, 100, 0, 0, 1, 16);
        eng(1, 15, 100, 100, 0, 0, 0, 15);
        eng(1, 15, 10, 100, 0, 0, 1, 10);
        eng(1, 5, 100, 100, 1, 0, 1, 5);
        eng(1, 300, 300, 300, 0, 0, 1, 128);
        eng(0, 64, 200, 200, 0, 0, 1, 64);
        eng(0, 63, 200, 200, 0, 0, 0, 63);
        eng(0, 63, 20, 200, 0, 0, 1, 20);
        eng(0, 300, 300, 300, 0, 1, 0, 128);
        eng(0, 300, 300, 40, 0, 0, 1, 40);
        eng(2, 16, 100, 100, 0, 0, 1, 16);
        eng(2, 15, 100, 100, 0, 0, 0, 15);
        eng(2, 300, 300, 300, 0, 0, 1, 128);
        eng(3, 15, 10, 100, 0, 0, 1, 10);
        eng(3, 300, 300, 300, 0, 0, 1, 128);
        I_CACHE_LINE = 8'h08;
        eng(2, 300, 300, 300, 0, 0, 1, 8);
        I_CACHE_LINE = 8'h00;
        acc(0, 12'h800, 32'h0000_ff2f);
        acc(0, 12'h808, 32'h0010_3f5f);
        eng(0, 300, 300, 300, 0, 0, 1, 256);
        eng(0, 255, 300, 300, 0, 0, 0, 255);
        eng(1, 300, 300, 300, 0, 0, 1, 48);
        eng(2, 255, 300, 300, 0, 0, 0, 64);
        eng(3, 255, 300, 300, 0, 0, 0, 96);
        $display("test engines done");
        pr(256, 0, 0, 1);
        pr(255, 0, 0, 0);
        pr(3, 1, 0, 1);
        acc(0, 12'h808, 32'h0108_7373);
        pr(200, 0, 1, 0);
        pr(512, 0, 1, 1);
        acc(0, 12'h808, 32'h0008_7373);
        pr(200, 0, 1, 1);
        $display("test packet ready done");
        I_TX_VALID = 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            I_TX_DATA = $random(seed);
            if (O_TX_READY !== 1'b1)
                break;
            q_link.push_back(I_TX_DATA);
            n_acc++;
            tick;
        end
        I_TX_VALID = 1'b0;
        chk("words taken", 32'h0000_0008, n_acc);
        hold = 1'b0;
        for (int i = 0; i < 300 && q_link.size() != 0; i++)
            tick;
        tick;
        chk1("drained", 1'b0, O_LINK_VALID);
        // a reset in mid-run must bring back the defaults
        I_SYS_RST = 1'b1;
        repeat (2) tick;
        I_SYS_RST = 1'b0;
        acc(1, 12'h800, 32'h0000_7373);
        acc(1, 12'h808, 32'h0010_7373);
        chk("pending", 32'h0000_0000, q_reg.size() + q_link.size());
        $display("test fifo done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
